// File: cpmc_pkg.sv
// Purpose: constants for the counter/pulse mode control unit
// Assumes: 250 MHz REF_CLK, AXI4-Lite register access
// Notes: register offsets are byte addresses
package cpmc_pkg;
  // port codes
  localparam logic [15:0] PORT_PULSE_BASE = 16'h0000;
  localparam logic [15:0] PORT_HSC_BASE = 16'h0010;
  localparam logic [15:0] PORT_CNTIN_BASE = 16'h0100;
  localparam logic [15:0] PORT_PWM_BASE = 16'h1000;
  localparam int NUM_PULSE = 4;
  localparam int NUM_HSC = 4;
  localparam int NUM_CNTIN = 8;
  localparam int NUM_PWM = 2;
  // control codes
  localparam logic [15:0] CTL_START_CMP = 16'h0000;
  localparam logic [15:0] CTL_STOP_CMP = 16'h0001;
  localparam logic [15:0] CTL_CHANGE_PV = 16'h0002;
  localparam logic [15:0] CTL_STOP_PULSE = 16'h0003;
  // limits
  localparam logic [31:0] CNTIN_PV_MAX = 32'h0000FFFF;
  // register offsets
  localparam logic [7:0] REG_PORT = 8'h00;
  localparam logic [7:0] REG_CTRL = 8'h04;
  localparam logic [7:0] REG_NV_LO = 8'h08;
  localparam logic [7:0] REG_NV_HI = 8'h0C;
  localparam logic [7:0] REG_CMD = 8'h10;
  localparam logic [7:0] REG_RESULT = 8'h14;
  localparam logic [7:0] REG_CONFIG = 8'h18;
  localparam logic [7:0] REG_STATE = 8'h1C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h20;
  localparam logic [7:0] REG_IRQ_CLR = 8'h24;
  localparam logic [7:0] REG_IRQ_EN = 8'h28;
  localparam logic [7:0] REG_PV_SEL = 8'h2C;
  localparam logic [7:0] REG_PV_READ = 8'h30;
  // field positions of REG_CMD
  localparam int CMD_GO_BIT = 0;
  localparam int CMD_EDGE_BIT = 1;
  localparam int CMD_COND_BIT = 2;
  localparam int CMD_INTASK_BIT = 3;
  // field positions of REG_CONFIG
  localparam int CFG_HSC_EN_LSB = 0;
  localparam int CFG_HSC_RING_LSB = 4;
  localparam int CFG_HSC_INC_LSB = 8;
  localparam int CFG_CNTIN_EN_LSB = 16;
  localparam int CFG_REDUCED_BIT = 24;
  // field positions of REG_STATE; TABLE_REG_BUSY reads back at bit 19, not at ST_TBL_BUSY_BIT
  localparam int ST_PULSE_RUN_LSB = 0;
  localparam int ST_CMP_RUN_LSB = 4;
  localparam int ST_TABLE_LSB = 8;
  localparam int ST_AMOUNT_LSB = 12;
  localparam int ST_PWM_RUN_LSB = 16;
  localparam int ST_TBL_BUSY_BIT = 20;
  // irq bits
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  // reset values
  localparam logic [31:0] CONFIG_RST = 32'h00000000;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {CPMC_PULSE, CPMC_HSC, CPMC_CNTIN, CPMC_PWM} cpmc_kind_t;
endpackage

// File: cpmc_top.sv
// Purpose: executes mode-control requests for counters, pulse and PWM outputs
// Assumes: inputs synchronous to REF_CLK; single clock domain
// Notes: the outer counter and pulse engines follow the state outputs
//
// Local design decisions: the AXI4-Lite interface to the registers and the placing of the registers.
module cpmc_top
  import cpmc_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // engine events
  input wire logic [NUM_PULSE-1:0] PULSE_START,
  input wire logic [NUM_PWM-1:0] PWM_START,
  input wire logic [NUM_HSC-1:0] TABLE_REGISTERED,
  input wire logic TABLE_REG_BUSY,
  // engine controls
  output logic [NUM_PULSE-1:0] PULSE_RUN,
  output logic [NUM_PULSE-1:0] PULSE_AMOUNT_VALID,
  output logic [NUM_PWM-1:0] PWM_RUN,
  output logic [NUM_HSC-1:0] CMP_RUN,
  output logic [4:0] PV_LOAD_PORT,
  output logic [31:0] PV_LOAD_VALUE,
  output logic PV_LOAD,
  output logic ERROR_FLAG,
  output logic IRQ
);
  if (ADDR_W < 8)
  begin : g_addr_check
    $error("ADDR_W too small");
  end

  logic [15:0] port_code;
  logic [15:0] ctrl_code;
  logic [31:0] nv_lo;
  logic [31:0] nv_hi;
  logic [31:0] config_reg;
  logic [NUM_HSC-1:0] table_ok;
  logic [1:0] irq_stat;
  logic [1:0] irq_en;
  logic [31:0] pulse_pv [NUM_PULSE];
  logic [1:0] pv_sel;
  logic cond_prev;
  logic go;
  logic in_task;
  logic done_evt;
  logic aw_hold;
  logic w_hold;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic wr_fire;

  // request decode
  function automatic logic port_in(input logic [15:0] p, input logic [15:0] base,
                                   input int n);
    logic [15:0] d;
    d = p - base;
    return (p >= base) && (d < 16'(n));
  endfunction

  function automatic logic in_range_u(input logic [31:0] v, input logic [31:0] lim);
    return v <= lim;
  endfunction

  logic is_pulse, is_hsc, is_cntin, is_pwm;
  logic [2:0] idx;
  logic [31:0] new_val;
  logic bad_pair, bad_range, bad_state, req_err;
  cpmc_kind_t kind;

  always_comb
  begin
    is_pulse = port_in(port_code, PORT_PULSE_BASE, NUM_PULSE);
    is_hsc = port_in(port_code, PORT_HSC_BASE, NUM_HSC);
    is_cntin = port_in(port_code, PORT_CNTIN_BASE, NUM_CNTIN);
    is_pwm = port_in(port_code, PORT_PWM_BASE, NUM_PWM);
    idx = port_code[2:0];
    kind = is_hsc ? CPMC_HSC : is_cntin ? CPMC_CNTIN : is_pwm ? CPMC_PWM : CPMC_PULSE;
    new_val = (ctrl_code == CTL_CHANGE_PV) ? {nv_hi[15:0], nv_lo[15:0]} : 32'h00000000;
    bad_pair = 1'b1;
    if (ctrl_code <= CTL_STOP_PULSE)
    begin
      unique case (kind)
        CPMC_PULSE: bad_pair = !is_pulse ||
          !(ctrl_code == CTL_CHANGE_PV || ctrl_code == CTL_STOP_PULSE);
        CPMC_HSC: bad_pair = ctrl_code == CTL_STOP_PULSE;
        CPMC_CNTIN: bad_pair = ctrl_code != CTL_CHANGE_PV;
        CPMC_PWM: bad_pair = ctrl_code != CTL_STOP_PULSE;
      endcase
    end
    bad_range = 1'b0;
    bad_state = 1'b0;
    if (!bad_pair)
    begin
      // interrupt input not in counter mode
      if (is_cntin && (!config_reg[CFG_CNTIN_EN_LSB + 32'(idx)] ||
          (config_reg[CFG_REDUCED_BIT] && idx >= 3'h6)))
        bad_state = 1'b1;
      if (is_cntin && !in_range_u(new_val, CNTIN_PV_MAX))
        bad_range = 1'b1;
      if (is_hsc && !config_reg[CFG_HSC_EN_LSB + 32'(idx[1:0])])
        bad_state = 1'b1;
      if (is_hsc && ctrl_code == CTL_START_CMP && !table_ok[idx[1:0]])
        bad_state = 1'b1;
      if (is_pulse && ctrl_code == CTL_CHANGE_PV && PULSE_RUN[idx[1:0]])
        bad_state = 1'b1;
      if (in_task && TABLE_REG_BUSY)
        bad_state = 1'b1;
    end
    req_err = bad_pair || bad_range || bad_state;
  end

  logic cmd_cond, cmd_edge, cmd_trig;
  always_comb
  begin
    cmd_cond = w_data[CMD_COND_BIT];
    cmd_edge = w_data[CMD_EDGE_BIT];
    cmd_trig = w_data[CMD_GO_BIT] || (cmd_edge ? (cmd_cond && !cond_prev) : cmd_cond);
  end

  // axi write path
  assign S_AXI_AWREADY = !aw_hold && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_hold && !S_AXI_BVALID;
  assign wr_fire = aw_hold && w_hold && !S_AXI_BVALID;

  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h00000000;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= AXI_OKAY;
    end
    else if (CLK_EN)
    begin
      if (S_AXI_AWVALID && S_AXI_AWREADY)
      begin
        aw_hold <= 1'b1;
        aw_addr <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY)
      begin
        w_hold <= 1'b1;
        w_data <= S_AXI_WDATA;
      end
      if (wr_fire)
      begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= (aw_addr[7:0] <= REG_PV_SEL && aw_addr[1:0] == 2'h0 &&
          aw_addr[7:0] != REG_RESULT && aw_addr[7:0] != REG_STATE &&
          aw_addr[7:0] != REG_IRQ_STAT) ? AXI_OKAY : AXI_SLVERR;
      end
      else if (S_AXI_BVALID && S_AXI_BREADY)
        S_AXI_BVALID <= 1'b0;
    end
  end

  // software registers
  logic wr_cmd;
  assign wr_cmd = wr_fire && aw_addr[7:0] == REG_CMD;
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      port_code <= 16'h0000;
      ctrl_code <= 16'h0000;
      nv_lo <= 32'h00000000;
      nv_hi <= 32'h00000000;
      config_reg <= CONFIG_RST;
      irq_en <= 2'h0;
      pv_sel <= 2'h0;
      cond_prev <= 1'b0;
      go <= 1'b0;
      in_task <= 1'b0;
    end
    else if (CLK_EN)
    begin
      go <= 1'b0;
      if (wr_fire)
      begin
        unique case (aw_addr[7:0])
          REG_PORT: port_code <= w_data[15:0];
          REG_CTRL: ctrl_code <= w_data[15:0];
          REG_NV_LO: nv_lo <= w_data;
          REG_NV_HI: nv_hi <= w_data;
          REG_CONFIG: config_reg <= w_data;
          REG_IRQ_EN: irq_en <= w_data[1:0];
          REG_PV_SEL: pv_sel <= w_data[1:0];
          default: ;
        endcase
      end
      if (wr_cmd)
      begin
        cond_prev <= cmd_cond;
        go <= cmd_trig;
        in_task <= w_data[CMD_INTASK_BIT];
      end
    end
  end

  // execution
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ERROR_FLAG <= 1'b0;
      PULSE_RUN <= '0;
      PULSE_AMOUNT_VALID <= '0;
      PWM_RUN <= '0;
      CMP_RUN <= '0;
      table_ok <= '0;
      PV_LOAD <= 1'b0;
      PV_LOAD_PORT <= 5'h00;
      PV_LOAD_VALUE <= 32'h00000000;
      done_evt <= 1'b0;
      for (int i = 0; i < NUM_PULSE; i++)
        pulse_pv[i] <= 32'h00000000;
    end
    else if (CLK_EN)
    begin
      PV_LOAD <= 1'b0;
      done_evt <= go;
      table_ok <= table_ok | TABLE_REGISTERED;
      PULSE_RUN <= PULSE_RUN | PULSE_START;
      PULSE_AMOUNT_VALID <= PULSE_AMOUNT_VALID | PULSE_START;
      PWM_RUN <= PWM_RUN | PWM_START;
      if (go)
      begin
        ERROR_FLAG <= req_err;
        if (!req_err)
        begin
          unique case (ctrl_code)
            CTL_START_CMP: CMP_RUN[idx[1:0]] <= 1'b1;
            CTL_STOP_CMP: CMP_RUN[idx[1:0]] <= 1'b0;
            // full 32-bit value taken; sign per mode
            CTL_CHANGE_PV:
            begin
              PV_LOAD <= 1'b1;
              PV_LOAD_PORT <= {kind == CPMC_CNTIN, is_hsc, idx};
              PV_LOAD_VALUE <= new_val;
              if (is_pulse)
                pulse_pv[idx[1:0]] <= new_val;
            end
            CTL_STOP_PULSE:
            begin
              if (is_pwm)
                PWM_RUN[idx[0]] <= 1'b0;
              else if (PULSE_RUN[idx[1:0]])
                PULSE_RUN[idx[1:0]] <= 1'b0;
              else
                PULSE_AMOUNT_VALID[idx[1:0]] <= 1'b0;
            end
            default: ;
          endcase
        end
      end
    end
  end

  // interrupt status, set wins over clear
  logic [1:0] irq_clr;
  assign irq_clr = (wr_fire && aw_addr[7:0] == REG_IRQ_CLR) ? w_data[1:0] : 2'h0;
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
      irq_stat <= 2'h0;
    else if (CLK_EN)
    begin
      irq_stat <= (irq_stat & ~irq_clr) | {done_evt && ERROR_FLAG, done_evt};
    end
  end
  assign IRQ = |(irq_stat & irq_en);

  // axi read path
  logic [31:0] rd_val;
  logic rd_ok;
  always_comb
  begin
    rd_ok = 1'b1;
    rd_val = 32'h00000000;
    unique case (S_AXI_ARADDR[7:0])
      REG_PORT: rd_val = {16'h0000, port_code};
      REG_CTRL: rd_val = {16'h0000, ctrl_code};
      REG_NV_LO: rd_val = nv_lo;
      REG_NV_HI: rd_val = nv_hi;
      REG_CMD: rd_val = 32'h00000000;
      REG_RESULT: rd_val = {31'h00000000, ERROR_FLAG};
      REG_CONFIG: rd_val = config_reg;
      REG_STATE: rd_val = 32'({TABLE_REG_BUSY, 1'b0, PWM_RUN, PULSE_AMOUNT_VALID,
        table_ok, CMP_RUN, PULSE_RUN});
      REG_IRQ_STAT: rd_val = {30'h00000000, irq_stat};
      REG_IRQ_CLR: rd_val = 32'h00000000;
      REG_IRQ_EN: rd_val = {30'h00000000, irq_en};
      REG_PV_SEL: rd_val = {30'h00000000, pv_sel};
      REG_PV_READ: rd_val = pulse_pv[pv_sel];
      default: rd_ok = 1'b0;
    endcase
  end

  assign S_AXI_ARREADY = !S_AXI_RVALID;
  always_ff @(posedge REF_CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h00000000;
      S_AXI_RRESP <= AXI_OKAY;
    end
    else if (CLK_EN)
    begin
      if (S_AXI_ARVALID && S_AXI_ARREADY)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_val;
        S_AXI_RRESP <= rd_ok ? AXI_OKAY : AXI_SLVERR;
      end
      else if (S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
    end
  end
endmodule

// File: cpmc_props.sv
// Purpose: port checker for cpmc_top
// Assumes: one clock, reset low and asynchronous
// Notes: bound to every cpmc_top
module cpmc_props
  import cpmc_pkg::*;
(
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  // bus answers
  input wire logic S_AXI_AWREADY,
  input wire logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // engine side
  input wire logic [NUM_PULSE-1:0] PULSE_START,
  input wire logic [NUM_HSC-1:0] TABLE_REGISTERED,
  input wire logic [NUM_PULSE-1:0] PULSE_RUN,
  input wire logic [NUM_PULSE-1:0] PULSE_AMOUNT_VALID,
  input wire logic [NUM_HSC-1:0] CMP_RUN,
  input wire logic [4:0] PV_LOAD_PORT,
  input wire logic [31:0] PV_LOAD_VALUE,
  input wire logic PV_LOAD,
  input wire logic ERROR_FLAG,
  input wire logic IRQ
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  logic [NUM_HSC-1:0] tbl_seen;
  // tables seen so far
  always_ff @(posedge REF_CLK or negedge RST_N)
    if (!RST_N)
      tbl_seen <= '0;
    else
      tbl_seen <= tbl_seen | TABLE_REGISTERED;
  a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write answer dropped");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA)) else $error("read answer dropped");
  a_aw_blocked: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
    else $error("address taken while answer pending");
  a_load_pulse: assert property (PV_LOAD |=> !PV_LOAD) else $error("load longer than one cycle");
  a_load_noerr: assert property (PV_LOAD |-> !ERROR_FLAG) else $error("load with error");
  a_cntin_range: assert property (PV_LOAD && PV_LOAD_PORT[4] |->
    PV_LOAD_VALUE <= CNTIN_PV_MAX) else $error("interrupt value too big");
  a_pulse_stopped: assert property (PV_LOAD && PV_LOAD_PORT[4:3] == 2'b00 |->
    ($past(PULSE_RUN) & (4'h1 << PV_LOAD_PORT[1:0])) == 4'h0)
    else $error("pulse value changed while running");
  a_cmp_table: assert property ((CMP_RUN & ~$past(CMP_RUN) & ~tbl_seen) == 4'h0)
    else $error("compare without table");
  a_cmp_noload: assert property ($rose(|CMP_RUN) |-> !PV_LOAD)
    else $error("start compare loaded value");
  a_amount_set: assert property (CLK_EN && |PULSE_START |=>
    (PULSE_AMOUNT_VALID & $past(PULSE_START)) == $past(PULSE_START))
    else $error("pulse amount not set");
  cover property (PV_LOAD);
  cover property ($rose(ERROR_FLAG));
  cover property ($rose(IRQ));
endmodule

bind cpmc_top cpmc_props chk_i (.REF_CLK(REF_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID),
  .S_AXI_RREADY(S_AXI_RREADY), .PULSE_START(PULSE_START),
  .TABLE_REGISTERED(TABLE_REGISTERED), .PULSE_RUN(PULSE_RUN),
  .PULSE_AMOUNT_VALID(PULSE_AMOUNT_VALID), .CMP_RUN(CMP_RUN), .PV_LOAD_PORT(PV_LOAD_PORT),
  .PV_LOAD_VALUE(PV_LOAD_VALUE), .PV_LOAD(PV_LOAD), .ERROR_FLAG(ERROR_FLAG), .IRQ(IRQ));

// File: cpmc_engine_model.sv
// Purpose: engine-side stand-in for cpmc_top
// Assumes: bench raises go levels
// Notes: each rise of go_pulse, go_pwm or go_table gives a one-cycle event; go_busy passes through as a level
module cpmc_engine_model
  import cpmc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bench commands
  input wire logic [NUM_PULSE-1:0] go_pulse,
  input wire logic [NUM_PWM-1:0] go_pwm,
  input wire logic [NUM_HSC-1:0] go_table,
  input wire logic go_busy,
  // engine events
  output logic [NUM_PULSE-1:0] pulse_start,
  output logic [NUM_PWM-1:0] pwm_start,
  output logic [NUM_HSC-1:0] table_done,
  output logic table_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] last_go;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      last_go <= '0;
      {pulse_start, pwm_start, table_done} <= '0;
      table_busy <= 1'b0;
    end
    else
    begin
      last_go <= {go_pulse, go_pwm, go_table};
      {pulse_start, pwm_start, table_done} <= {go_pulse, go_pwm, go_table} & ~last_go;
      table_busy <= go_busy;
    end
endmodule

// File: counter_pulse_mode_control_test.sv
// Purpose: request-level test of cpmc_top
// Assumes: 250 MHz clock, bus master tasks
// Notes: expectations follow port and code tables
module counter_pulse_mode_control_test
  import cpmc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, awv, wv, br, arv, rr, awr, wr_, bv, arr, rv, busy, bsy, ld, err, irq;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdat, ldv, ld_val;
  logic [1:0] bresp, rresp, gpwm, pwms, pwmr;
  logic [3:0] gp, gt, ps, tr, prun, pamt, cmp;
  logic [4:0] ldp, ld_port;
  int n_mismatch, n_tests, n_load;
  cpmc_top uut (.REF_CLK(clk), .RST_N(rst_n), .CLK_EN(1'b1), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(br), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rr),
    .PULSE_START(ps), .PWM_START(pwms), .TABLE_REGISTERED(tr), .TABLE_REG_BUSY(bsy),
    .PULSE_RUN(prun), .PULSE_AMOUNT_VALID(pamt), .PWM_RUN(pwmr), .CMP_RUN(cmp),
    .PV_LOAD_PORT(ldp), .PV_LOAD_VALUE(ldv), .PV_LOAD(ld), .ERROR_FLAG(err), .IRQ(irq));
  cpmc_engine_model eng (.clk(clk), .rst_n(rst_n), .go_pulse(gp), .go_pwm(gpwm),
    .go_table(gt), .go_busy(busy), .pulse_start(ps), .pwm_start(pwms), .table_done(tr),
    .table_busy(bsy));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // value loads seen
  always @(negedge clk)
    if (ld === 1'b1)
    begin
      n_load++;
      ld_val = ldv;
      ld_port = ldp;
    end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task test_done;
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task tmo(input int k);
    if (k >= 40)
    begin
      n_mismatch++;
      $display("[FAIL] %0t no bus answer", $time);
      test_done;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int k;
    logic ta, tw, ga, gw;
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
    ta = 1'b1; tw = 1'b1;
    for (k = 0; (ta | tw) && k < 40; k++)
    begin
      @(negedge clk);
      ga = ta & (awr === 1'b1); gw = tw & (wr_ === 1'b1);
      @(posedge clk);
      if (ga) begin awv <= 1'b0; ta = 1'b0; end
      if (gw) begin wv <= 1'b0; tw = 1'b0; end
    end
    tmo(k);
    k = 0;
    do begin @(negedge clk); k++; end while (bv !== 1'b1 && k < 40);
    tmo(k);
    chk(bresp, r);
    @(posedge clk);
    br <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int k;
    logic g;
    @(posedge clk);
    ara <= a; arv <= 1'b1; rr <= 1'b1;
    g = 1'b0;
    for (k = 0; !g && k < 40; k++)
    begin
      @(negedge clk);
      g = (arr === 1'b1);
      @(posedge clk);
    end
    arv <= 1'b0;
    tmo(k);
    k = 0;
    do begin @(negedge clk); k++; end while (rv !== 1'b1 && k < 40);
    tmo(k);
    chk(rdat, d);
    chk(rresp, r);
    @(posedge clk);
    rr <= 1'b0;
  endtask
  task automatic run(input logic [15:0] p, input logic [15:0] c, input logic [31:0] v,
                     input logic [3:0] m, input logic e);
    wr(REG_PORT, {16'h0000, p}, AXI_OKAY);
    wr(REG_CTRL, {16'h0000, c}, AXI_OKAY);
    wr(REG_NV_LO, {16'h0000, v[15:0]}, AXI_OKAY);
    wr(REG_NV_HI, {16'h0000, v[31:16]}, AXI_OKAY);
    wr(REG_CMD, {28'h0000000, m}, AXI_OKAY);
    rd(REG_RESULT, {31'h00000000, e}, AXI_OKAY);
    chk(err, e);
  endtask
  logic [64:0] cs [14] = '{{16'h0011, 16'h0000, 32'h0, 1'b1}, {16'h0000, 16'h0000, 32'h0, 1'b1},
    {16'h1001, 16'h0003, 32'h0, 1'b0}, {16'h0000, 16'h0001, 32'h0, 1'b1},
    {16'h0012, 16'h0002, 32'hFFFFFFFF, 1'b0}, {16'h0013, 16'h0002, 32'h1, 1'b1},
    {16'h0105, 16'h0002, 32'h1, 1'b1}, {16'h0106, 16'h0002, 32'h1, 1'b1},
    {16'h0020, 16'h0002, 32'h1, 1'b1}, {16'h0010, 16'h0004, 32'h0, 1'b1},
    {16'h1000, 16'h0002, 32'h0, 1'b1}, {16'h0100, 16'h0002, 32'h00010000, 1'b1},
    {16'h0012, 16'h0003, 32'h0, 1'b1}, {16'h0100, 16'h0000, 32'h0, 1'b1}};
  initial
  begin
    int nl;
    {rst_n, awv, wv, br, arv, rr, busy, gp, gpwm, gt, awa, ara, wd} = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(REG_CONFIG, CONFIG_RST, AXI_OKAY);
    wr(8'h40, 32'h1, AXI_SLVERR);
    rd(8'h40, 32'h0, AXI_SLVERR);
    wr(REG_RESULT, 32'h1, AXI_SLVERR);
    wr(REG_CONFIG, 32'h01DF0007, AXI_OKAY);
    wr(REG_IRQ_EN, 32'h2, AXI_OKAY);
    gt <= 4'h1;
    for (int i = 0; i < 14; i++)
      run(cs[i][64:49], cs[i][48:33], cs[i][32:1], 4'h1, cs[i][0]);
    nl = n_load;
    run(16'h0010, CTL_START_CMP, 32'h12345678, 4'h1, 1'b0);
    chk(cmp, 4'h1);
    chk(32'(n_load), 32'(nl));
    run(16'h0010, CTL_STOP_CMP, 32'h0, 4'h1, 1'b0);
    chk(cmp, 4'h0);
    run(16'h0100, CTL_CHANGE_PV, CNTIN_PV_MAX, 4'h1, 1'b0);
    chk({ld_port, ld_val}, {5'h10, CNTIN_PV_MAX});
    gp <= 4'h1;
    gpwm <= 2'h1;
    repeat (2) @(posedge clk);
    rd(REG_STATE, 32'h00011101, AXI_OKAY);
    run(16'h0000, CTL_CHANGE_PV, 32'h80000000, 4'h1, 1'b1);
    run(16'h0000, CTL_STOP_PULSE, 32'h0, 4'h1, 1'b0);
    chk({prun, pamt}, 8'h01);
    run(16'h0000, CTL_STOP_PULSE, 32'h0, 4'h1, 1'b0);
    chk(pamt, 4'h0);
    run(16'h1000, CTL_STOP_PULSE, 32'h0, 4'h1, 1'b0);
    chk(pwmr, 2'h0);
    run(16'h0000, CTL_CHANGE_PV, 32'h80000000, 4'h1, 1'b0);
    chk({ld_port, ld_val}, {5'h00, 32'h80000000});
    busy <= 1'b1;
    run(16'h0010, CTL_STOP_CMP, 32'h0, 4'h9, 1'b1);
    busy <= 1'b0;
    run(16'h0010, CTL_STOP_CMP, 32'h0, 4'h9, 1'b0);
    run(16'h0000, CTL_START_CMP, 32'h0, 4'h4, 1'b1);
    run(16'h0010, CTL_STOP_CMP, 32'h0, 4'h6, 1'b1);
    run(16'h0010, CTL_STOP_CMP, 32'h0, 4'h2, 1'b1);
    run(16'h0010, CTL_STOP_CMP, 32'h0, 4'h6, 1'b0);
    chk(irq, 1'b1);
    rd(REG_IRQ_STAT, 32'h3, AXI_OKAY);
    wr(REG_IRQ_CLR, 32'h3, AXI_OKAY);
    chk(irq, 1'b0);
    wr(REG_IRQ_EN, 32'h0, AXI_OKAY);
    run(16'h1001, CTL_START_CMP, 32'h0, 4'h1, 1'b1);
    chk(irq, 1'b0);
    wr(REG_IRQ_EN, 32'h2, AXI_OKAY);
    chk(irq, 1'b1);
    test_done;
  end
endmodule
